// File: adcc_top.v
// Successive-approximation converter control with APB registers and pin routing.
//
// Overview of operation
// - Four sample ticks, then twelve convert ticks
// - Start pulse low-high-low begins conversion
// - Busy flag high while converting
// - Busy falls at end; result readable
// - Enable cleared powers converter down
// - Twelve-bit unsigned result, full scale FFF
// - Reference source chosen with gain 1-4
// - Selected reference driven on output pin
// - Internal source disconnects all external channels
// - Analog pin drops function and pull-up
// - Analog pin overrides port direction
// - Four-bit reference code decode table
// - Divider code gives divide by 2^n
// - Completion sets flag, raises interrupt
`timescale 1ns/1ps
`include "adcc_defines.vh"
module adcc_top (
    // APB clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Analog front end
    input wire [11:0] sar_data,
    output reg sar_power_on_r,
    output reg sar_sample_r,
    output reg sar_convert_r,
    output reg [7:0] chan_connect_r,
    output reg internal_sel_r,
    output reg [2:0] internal_src_r,
    output reg [1:0] ref_source_r,
    output reg [2:0] ref_gain_r,
    output reg ref_out_en_r,
    // Pin control
    output reg [7:0] pin_func_disable_r,
    output reg [7:0] pin_pullup_en_r,
    output reg [7:0] pin_output_en_r,
    // Interrupt request
    output reg irq_r
);
    reg [7:0] ctrl0_r;
    reg [7:0] ctrl1_r;
    reg [3:0] ref_sel_r;
    reg ref_pin_sel_r;
    reg [7:0] analog_pin_r;
    reg [7:0] pullup_r;
    reg [7:0] portdir_r;
    reg gie_r;
    reg ie_r;
    reg flag_r;
    reg busy_r;
    reg [11:0] result_r;
    reg [4:0] tick_cnt_r;
    reg start_prev_r;
    reg start_armed_r;
    wire tick;
    wire wr;
    wire rd;
    wire start_fall;
    wire done;
    wire [2:0] src;
    wire [2:0] chan;
    wire launch;

    // Per-pin next values for the routing and pin control outputs.
    wire ext_route;
    wire [7:0] chan_onehot;
    wire [7:0] chan_connect_nxt;
    wire [7:0] pin_pullup_nxt;
    wire [7:0] pin_output_nxt;
    reg [1:0] ref_source_nxt;
    reg [2:0] ref_gain_nxt;

    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign src = ctrl1_r[`ADCC_C1_SRC_LSB +: 3];
    assign chan = ctrl0_r[`ADCC_C0_CHAN_LSB +: 3];
    assign start_fall = start_prev_r & ~ctrl0_r[`ADCC_C0_START];
    assign done = busy_r & tick & (tick_cnt_r == `ADCC_TOTAL_CYC - 5'h01);
    // A launch restarts the divider, so the sampling window always spans four whole periods.
    assign launch = ctrl0_r[`ADCC_C0_ENABLE] & start_fall & start_armed_r;
    // External channels only route while powered and while no internal source is chosen.
    assign ext_route = (src == `ADCC_SRC_EXT) & ctrl0_r[`ADCC_C0_ENABLE];
    assign chan_onehot = 8'h01 << chan;

    adcc_clkdiv u_div (
        .pclk(pclk),
        .presetn(presetn),
        .restart(launch),
        .div_sel(ctrl1_r[`ADCC_C1_DIV_LSB +: 3]),
        .tick_r(tick)
    );

    // Per-pin routing: an analog pin loses its function, its pull-up and its driver.
    genvar gi;
    generate
        for (gi = 0; gi < `ADCC_NPINS; gi = gi + 1) begin : g_pin
            assign chan_connect_nxt[gi] = ext_route & chan_onehot[gi] & analog_pin_r[gi];
            assign pin_pullup_nxt[gi] = pullup_r[gi] & ~analog_pin_r[gi];
            assign pin_output_nxt[gi] = portdir_r[gi] & ~analog_pin_r[gi];
        end
    endgenerate

    // Register writes.
    // The busy bit is read-only; its written value is stored but never read back.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_r <= 8'h00;
            ctrl1_r <= 8'h00;
            ref_sel_r <= 4'h0;
            ref_pin_sel_r <= 1'b0;
            analog_pin_r <= 8'h00;
            pullup_r <= 8'h00;
            portdir_r <= 8'h00;
            gie_r <= 1'b0;
            ie_r <= 1'b0;
        end else if (wr) begin
            case (paddr)
                `ADCC_OFF_CTRL0: ctrl0_r <= pwdata[7:0];
                `ADCC_OFF_CTRL1: ctrl1_r <= pwdata[7:0];
                `ADCC_OFF_CTRL2: begin
                    ref_sel_r <= pwdata[3:0];
                    ref_pin_sel_r <= pwdata[4];
                end
                `ADCC_OFF_INT: begin
                    gie_r <= pwdata[`ADCC_INT_GLOBAL];
                    ie_r <= pwdata[`ADCC_INT_ENABLE];
                end
                `ADCC_OFF_PINSEL: analog_pin_r <= pwdata[7:0];
                `ADCC_OFF_PULLUP: pullup_r <= pwdata[7:0];
                `ADCC_OFF_PORTDIR: portdir_r <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Start detection: a rise arms, the following fall launches.
    // Clearing enable disarms, so a pulse written while unpowered never launches later.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_prev_r <= 1'b0;
            start_armed_r <= 1'b0;
        end else begin
            start_prev_r <= ctrl0_r[`ADCC_C0_START];
            if (!ctrl0_r[`ADCC_C0_ENABLE]) begin
                start_armed_r <= 1'b0;
            end else if (ctrl0_r[`ADCC_C0_START] & ~start_prev_r) begin
                start_armed_r <= 1'b1;
            end else if (start_fall) begin
                start_armed_r <= 1'b0;
            end
        end
    end

    // Conversion sequencer counts converter ticks; a new start restarts it.
    // A launch outranks a completion in the same cycle: the flag sets, the old result stays.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r <= 1'b0;
            tick_cnt_r <= 5'h00;
            result_r <= 12'h000;
        end else if (!ctrl0_r[`ADCC_C0_ENABLE]) begin
            busy_r <= 1'b0;
            tick_cnt_r <= 5'h00;
        end else if (launch) begin
            busy_r <= 1'b1;
            tick_cnt_r <= 5'h00;
        end else if (done) begin
            busy_r <= 1'b0;
            result_r <= sar_data & `ADCC_FULL_SCALE;
            tick_cnt_r <= 5'h00;
        end else if (busy_r & tick) begin
            tick_cnt_r <= tick_cnt_r + 5'h01;
        end
    end

    // Completion flag: hardware set wins over a software clear in the same cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            if (done) begin
                flag_r <= 1'b1;
            end else if (wr && paddr == `ADCC_OFF_INT) begin
                flag_r <= pwdata[`ADCC_INT_FLAG];
            end
            // The request follows the flag, so it stays high until software clears the flag or either enable.
            irq_r <= (flag_r | done) & gie_r & ie_r;
        end
    end

    // Analog front-end and pin outputs, all registered.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sar_power_on_r <= 1'b0;
            sar_sample_r <= 1'b0;
            sar_convert_r <= 1'b0;
            chan_connect_r <= 8'h00;
            internal_sel_r <= 1'b0;
            internal_src_r <= 3'h0;
            ref_source_r <= `ADCC_REF_SUPPLY;
            ref_gain_r <= 3'h1;
            ref_out_en_r <= 1'b0;
            pin_func_disable_r <= 8'h00;
            pin_pullup_en_r <= 8'h00;
            pin_output_en_r <= 8'h00;
        end else begin
            // Power follows the enable bit; with it low no external channel switch closes, and sample and convert clear one cycle after power drops.
            sar_power_on_r <= ctrl0_r[`ADCC_C0_ENABLE];
            sar_sample_r <= busy_r & (tick_cnt_r < {1'b0, `ADCC_SAMPLE_CYC});
            sar_convert_r <= busy_r & (tick_cnt_r >= {1'b0, `ADCC_SAMPLE_CYC});
            internal_sel_r <= (src != `ADCC_SRC_EXT);
            internal_src_r <= src;
            // Only analog-assigned pins may reach the converter.
            chan_connect_r <= chan_connect_nxt;
            pin_func_disable_r <= analog_pin_r;
            pin_pullup_en_r <= pin_pullup_nxt;
            pin_output_en_r <= pin_output_nxt;
            ref_out_en_r <= ref_pin_sel_r & ctrl0_r[`ADCC_C0_ENABLE];
            ref_source_r <= ref_source_nxt;
            ref_gain_r <= ref_gain_nxt;
        end
    end

    // Reference decode; the supply never passes through the gain stage.
    always @* begin
        ref_source_nxt = `ADCC_REF_SUPPLY;
        ref_gain_nxt = 3'h1;
        case (ref_sel_r)
            4'h1, 4'h2, 4'h3, 4'h4: begin
                ref_source_nxt = `ADCC_REF_EXT;
                ref_gain_nxt = ref_sel_r[2:0];
            end
            4'hA, 4'hB, 4'hC: begin
                ref_source_nxt = `ADCC_REF_BANDGAP;
                ref_gain_nxt = ref_sel_r[2:0];
            end
            4'h9: begin
                // Reserved code: fall back to supply, unity gain.
                ref_source_nxt = `ADCC_REF_SUPPLY;
                ref_gain_nxt = 3'h1;
            end
            default: begin
                ref_source_nxt = `ADCC_REF_SUPPLY;
                ref_gain_nxt = 3'h1;
            end
        endcase
    end

    // APB read and answer; zero wait states.
    // Read data is captured in the setup cycle and stands with the one-cycle pready.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel & ~penable) begin
                prdata <= 32'h00000000;
                case (paddr)
                    `ADCC_OFF_CTRL0: prdata <= {24'h000000, ctrl0_r[7],
                        busy_r, ctrl0_r[5:0]};
                    `ADCC_OFF_CTRL1: prdata <= {24'h000000, ctrl1_r};
                    `ADCC_OFF_CTRL2: prdata <= {27'h0000000, ref_pin_sel_r, ref_sel_r};
                    `ADCC_OFF_RES_HI: prdata <= ctrl0_r[`ADCC_C0_FMT] ?
                        {28'h0000000, result_r[11:8]} : {24'h000000, result_r[11:4]};
                    `ADCC_OFF_RES_LO: prdata <= ctrl0_r[`ADCC_C0_FMT] ?
                        {24'h000000, result_r[7:0]} : {24'h000000, result_r[3:0], 4'h0};
                    `ADCC_OFF_INT: prdata <= {29'h00000000, flag_r, ie_r, gie_r};
                    `ADCC_OFF_PINSEL: prdata <= {24'h000000, analog_pin_r};
                    `ADCC_OFF_PULLUP: prdata <= {24'h000000, pullup_r};
                    `ADCC_OFF_PORTDIR: prdata <= {24'h000000, portdir_r};
                    default: pslverr <= 1'b0;
                endcase
                if (!(paddr <= `ADCC_OFF_PORTDIR && paddr[1:0] == 2'h0)) begin
                    pslverr <= 1'b0;
                end
            end
            if (rd) begin
                pready <= 1'b0;
            end
        end
    end
endmodule // adcc_top

// File: adcc_defines.vh
// Constants for the converter control block: offsets, fields, source codes and timing.
`ifndef ADCC_DEFINES_VH
`define ADCC_DEFINES_VH
`define ADCC_OFF_CTRL0 12'h000
`define ADCC_OFF_CTRL1 12'h004
`define ADCC_OFF_CTRL2 12'h008
`define ADCC_OFF_RES_HI 12'h00C
`define ADCC_OFF_RES_LO 12'h010
`define ADCC_OFF_INT 12'h014
`define ADCC_OFF_PINSEL 12'h018
`define ADCC_OFF_PULLUP 12'h01C
`define ADCC_OFF_PORTDIR 12'h020
`define ADCC_C0_CHAN_LSB 0
`define ADCC_C0_FMT 4
`define ADCC_C0_ENABLE 5
`define ADCC_C0_BUSY 6
`define ADCC_C0_START 7
`define ADCC_C1_DIV_LSB 0
`define ADCC_C1_SRC_LSB 5
`define ADCC_INT_GLOBAL 0
`define ADCC_INT_ENABLE 1
`define ADCC_INT_FLAG 2
`define ADCC_SAMPLE_CYC 4'h4
`define ADCC_CONV_CYC 4'hC
`define ADCC_TOTAL_CYC 5'h10
`define ADCC_NPINS 8
`define ADCC_FULL_SCALE 12'hFFF
`define ADCC_SRC_EXT 3'h0
`define ADCC_REF_SUPPLY 2'h0
`define ADCC_REF_EXT 2'h1
`define ADCC_REF_BANDGAP 2'h2
`endif

// File: adcc_clkdiv.v
// Converter clock divider producing one-cycle tick enables.
`timescale 1ns/1ps
module adcc_clkdiv (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Launch restart, divider code and tick
    input wire restart,
    input wire [2:0] div_sel,
    output reg tick_r
);
    reg [6:0] cnt_r;
    wire [6:0] limit;
    assign limit = (7'h01 << div_sel) - 7'h01;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 7'h00;
            tick_r <= 1'b0;
        end else if (restart) begin
            // A free-running phase would shorten the first period; restart so it is whole.
            cnt_r <= 7'h01;
            tick_r <= (limit == 7'h00);
        end else if (cnt_r >= limit) begin
            cnt_r <= 7'h00;
            tick_r <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 7'h01;
            tick_r <= 1'b0;
        end
    end
endmodule // adcc_clkdiv

// File: adcc_sar_model.sv
// Analog core stand-in that offers a conversion code only while converting.
`timescale 1ns/1ps
module adcc_sar_model (
    // Core state
    input logic sar_power_on_r,
    input logic sar_convert_r,
    input logic [11:0] code,
    // Result
    output logic [11:0] sar_data
);
    // Outside a conversion the code is inverted, so a capture at the wrong time shows.
    assign sar_data = (sar_power_on_r && sar_convert_r) ? code : ~code;
endmodule // adcc_sar_model

// File: adcc_checker_assertions.sv
// Port-level assertions for the converter control block.
`timescale 1ns/1ps
module adcc_checker (
    // Clock and reset
    input logic pclk,
    input logic presetn,
    // Converter state
    input logic sar_power_on_r,
    input logic sar_sample_r,
    input logic sar_convert_r,
    input logic [7:0] chan_connect_r,
    input logic internal_sel_r,
    input logic [1:0] ref_source_r,
    input logic [2:0] ref_gain_r,
    // Pins and interrupt
    input logic [7:0] pin_func_disable_r,
    input logic [7:0] pin_pullup_en_r,
    input logic [7:0] pin_output_en_r,
    input logic irq_r
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    phase_excl_a: assert property (!(sar_sample_r && sar_convert_r))
        else $error("sample and convert overlap");
    samp_to_conv_a: assert property ($fell(sar_sample_r) && sar_power_on_r |-> sar_convert_r)
        else $error("sampling not followed by converting");
    power_off_a: assert property (!sar_power_on_r && $past(!sar_power_on_r)
        |-> !sar_sample_r && !sar_convert_r && chan_connect_r == 8'h00)
        else $error("unpowered converter still active");
    int_disc_a: assert property (internal_sel_r |-> chan_connect_r == 8'h00)
        else $error("external channel on with internal source");
    pin_gate_a: assert property ($onehot0(chan_connect_r)
        && (chan_connect_r & ~pin_func_disable_r) == 8'h00)
        else $error("channel on a non-analog pin");
    pullup_drop_a: assert property ((pin_pullup_en_r & pin_func_disable_r) == 8'h00)
        else $error("pull-up on analog pin");
    dir_over_a: assert property ((pin_output_en_r & pin_func_disable_r) == 8'h00)
        else $error("output driver on analog pin");
    gain_range_a: assert property (ref_gain_r inside {[3'h1:3'h4]}
        && (ref_source_r != 2'h0 || ref_gain_r == 3'h1))
        else $error("reference gain out of range");
    cover property ($fell(sar_convert_r));
    cover property ($rose(irq_r));
    cover property (internal_sel_r);
endmodule // adcc_checker
bind adcc_top adcc_checker chk (.pclk, .presetn, .sar_power_on_r, .sar_sample_r,
    .sar_convert_r, .chan_connect_r, .internal_sel_r, .ref_source_r, .ref_gain_r,
    .pin_func_disable_r, .pin_pullup_en_r, .pin_output_en_r, .irq_r);

// File: tb_adcc_top.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
module tb_adcc_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sar_power_on_r, sar_sample_r;
    logic sar_convert_r, internal_sel_r, ref_out_en_r, irq_r;
    logic [11:0] paddr, code, sar_data;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] chan_connect_r, pin_func_disable_r, pin_pullup_en_r, pin_output_en_r;
    logic [2:0] internal_src_r, ref_gain_r;
    logic [1:0] ref_source_r;
    int n_mismatch, checks, ns, nc;
    // Reference code beside the source and gain it should give.
    logic [8:0] rows [8] = '{{4'h0, 2'h0, 3'h1}, {4'h1, 2'h1, 3'h1}, {4'h3, 2'h1, 3'h3},
        {4'h4, 2'h1, 3'h4}, {4'h9, 2'h0, 3'h1}, {4'hA, 2'h2, 3'h2}, {4'hC, 2'h2, 3'h4},
        {4'hF, 2'h0, 3'h1}};
    adcc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .sar_data, .sar_power_on_r, .sar_sample_r, .sar_convert_r, .chan_connect_r,
        .internal_sel_r, .internal_src_r, .ref_source_r, .ref_gain_r, .ref_out_en_r,
        .pin_func_disable_r, .pin_pullup_en_r, .pin_output_en_r, .irq_r);
    adcc_sar_model model (.sar_power_on_r, .sar_convert_r, .code, .sar_data);
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (sar_sample_r === 1'b1) ns++;
        if (sar_convert_r === 1'b1) nc++;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task conclude;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One APB transfer; two idle edges follow, so registered outputs have settled when checked.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk(1'b0, 1'b1, "apb timeout");
            conclude();
        end
        repeat (2) @(posedge pclk);
    endtask
    task conv(input logic [2:0] div, input logic fmt, input logic [11:0] c);
        int n;
        n = 0;
        code <= c;
        apb(1'b1, 12'h004, {29'h0, div});
        ns = 0;
        nc = 0;
        apb(1'b1, 12'h000, {24'h0, 3'h5, fmt, 4'h0});
        apb(1'b1, 12'h000, {24'h0, 3'h1, fmt, 4'h0});
        apb(1'b0, 12'h000, 32'h0);
        chk(q[6], 1'b1, "busy");
        while (q[6] === 1'b1 && n < 1000) begin
            apb(1'b0, 12'h000, 32'h0);
            n++;
        end
        chk(n < 1000, 1'b1, "end of conversion");
        chk(ns, 4 << div, "sample cycles");
        chk(nc, 12 << div, "convert cycles");
        apb(1'b0, 12'h00C, 32'h0);
        chk(q, fmt ? {28'h0, c[11:8]} : {24'h0, c[11:4]}, "result high");
        apb(1'b0, 12'h010, 32'h0);
        chk(q, fmt ? {24'h0, c[7:0]} : {24'h0, c[3:0], 4'h0}, "result low");
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, code, n_mismatch, checks} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        chk({sar_power_on_r, chan_connect_r, irq_r, ref_gain_r}, 32'h1, "reset outputs");
        foreach (rows[i]) begin
            apb(1'b1, 12'h008, {28'h0, rows[i][8:5]});
            chk(ref_source_r, rows[i][4:3], "ref source");
            chk(ref_gain_r, rows[i][2:0], "ref gain");
        end
        $display("test reference decode done");
        apb(1'b1, 12'h01C, 32'hFF);
        apb(1'b1, 12'h020, 32'hFF);
        apb(1'b1, 12'h018, 32'h0F);
        apb(1'b1, 12'h000, 32'h25);
        chk(chan_connect_r, 8'h00, "non-analog channel");
        apb(1'b1, 12'h000, 32'h22);
        chk(chan_connect_r, 8'h04, "analog channel");
        chk(pin_func_disable_r, 8'h0F, "function off");
        chk(pin_pullup_en_r, 8'hF0, "pull-ups");
        chk(pin_output_en_r, 8'hF0, "directions");
        apb(1'b1, 12'h004, 32'hA0);
        chk({internal_sel_r, internal_src_r, chan_connect_r}, 12'hD00, "internal source");
        apb(1'b1, 12'h008, 32'h1A);
        chk(ref_out_en_r, 1'b1, "reference out");
        $display("test pin routing done");
        apb(1'b1, 12'h014, 32'h3);
        for (int d = 0; d < 8; d++) conv(d[2:0], d[0], (d == 7) ? 12'hFFF : 12'h5A3);
        chk(irq_r, 1'b1, "irq raised");
        apb(1'b0, 12'h014, 32'h0);
        chk(q[2], 1'b1, "irq flag");
        apb(1'b1, 12'h014, 32'h1);
        chk(irq_r, 1'b0, "irq masked");
        $display("test conversions done");
        apb(1'b1, 12'h000, 32'h80);
        apb(1'b1, 12'h000, 32'h00);
        chk({sar_power_on_r, sar_sample_r}, 2'h0, "powered down");
        code <= 12'h123;
        apb(1'b1, 12'h040, 32'hFFFF_FFFF);
        apb(1'b0, 12'h040, 32'h0);
        chk(q, 32'h0, "unmapped read");
        chk(pslverr, 1'b0, "no slave error");
        apb(1'b0, 12'h010, 32'h0);
        chk(q, 32'hF0, "result held");
        $display("test power down done");
        apb(1'b1, 12'h000, 32'hA0);
        apb(1'b1, 12'h000, 32'h20);
        presetn <= 1'b0;
        @(posedge pclk);
        chk({sar_power_on_r, sar_sample_r, irq_r, ref_gain_r}, 32'h1, "mid-run reset");
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(q, 32'h0, "control after reset");
        $display("test mid-run reset done");
        conclude();
    end
endmodule // tb_adcc_top
